// ### logic/tcbrc_pkg.sv
package tcbrc_pkg;
  // Register map, word aligned
  localparam logic [7:0] OFS_XFER_CTRL = 8'h00;
  localparam logic [7:0] OFS_BUS_EXT = 8'h04;
  localparam logic [7:0] OFS_VEC_BASE = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  // Transfer control fields
  localparam int XC_STOP_BIT = 0;
  localparam int XC_RCHAIN_BIT = 3;
  localparam int XC_SKIP_BIT = 4;
  localparam logic [7:0] XC_RESET = 8'h00;
  // Bus function extension fields
  localparam int BE_TIMER_LSB = 0;
  localparam int BE_TIMER_W = 5;
  localparam int BE_PRIO_BIT = 8;
  localparam int BE_CPUPRI_BIT = 9;
  localparam int BE_SHORT_BIT = 10;
  localparam int BE_BURST_BIT = 11;
  localparam int BE_BRST_REL_BIT = 12;
  localparam int BE_NOP_REL_BIT = 14;
  localparam int BE_LOCK_BIT = 15;
  localparam logic [15:0] BE_WMASK = 16'hdf1f;
  localparam logic [15:0] BE_RESET = 16'h0000;
  localparam logic [31:0] VB_RESET = 32'h0000_0000;
  // Interrupt status bits
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_STOP_BIT = 1;
  // Descriptor layout
  localparam logic [2:0] DESC_WORDS_SHORT = 3'h3;
  localparam logic [2:0] DESC_WORDS_LONG = 3'h4;
  localparam int DM_CHAIN_BIT = 31;
  localparam int DM_REPEAT_BIT = 30;
  localparam int DW_SRC = 1;
  localparam int DW_DST = 2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ARB = 4'h1,
    ST_VEC = 4'h2,
    ST_NOP = 4'h3,
    ST_DESC_RD = 4'h4,
    ST_DATA_RD = 4'h5,
    ST_DATA_WR = 4'h6,
    ST_DESC_WR = 4'h7,
    ST_GAP = 4'h8,
    ST_HALT = 4'h9
  } tcbrc_state_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [31:0] wdata;
  } tcbrc_reg_req_t;

  typedef struct packed {
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } tcbrc_mem_req_t;
endpackage

// ### logic/tcbrc_core.sv
`timescale 1ns/1ps
// Operation
// - Each activation compares its vector number with the previous activation's.
// - Matching vector with skip enabled starts the data move without fetches.
// - After a chained activation, vector and descriptor are always fetched again.
// - In repeat mode, repeat-chain enable decides chaining once the counter hits 0.
// - Address error or NMI while active sets the stop flag.
// - After such an event the bus is released before CPU handling proceeds.
// - Current data move finishes, then the engine halts in ST_HALT, skipping descriptor write-back unless it has already begun.
// - Stop flag clears only by writing 0 after reading it as 1.
// - Vector table entry address is vector base plus vector number times four.
// - Lock enable selects whether the bus is released between chained links.
// - Bit 14 lets a CPU external access take the bus in the post-vector idle cycle.
// - Bit 12 releases the bus during data reads and writes while a burst DMA transfer is in progress.
// - Burst enable keeps the bus until every pending activation is served.
// - Short mode selects 3-longword descriptors, else 4, for fetch and write-back.
// - Bit 9 gives CPU external memory accesses priority over the engine.
// - Priority bit selects arrival order or fixed source priority.
// - Bits 4..0 enable burst DMA starts from timer compare-match A interrupts.
module tcbrc_core #(
  parameter int NSRC = 8
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire tcbrc_pkg::tcbrc_reg_req_t regReq,
  output logic [31:0] regRdata,
  input wire logic [NSRC-1:0] actReq,
  input wire logic addrErr,
  input wire logic nmiReq,
  input wire logic cpuExtReq,
  input wire logic burstDmaBusy,
  input wire logic [4:0] timerCmpAIrq,
  output logic [4:0] burstDmaStart,
  output logic busReq,
  input wire logic busGnt,
  output logic busOwn,
  output logic memReq,
  output tcbrc_pkg::tcbrc_mem_req_t memCmd,
  input wire logic memAck,
  input wire logic [31:0] memRdata,
  output logic cpuHandlerOk,
  output logic xferDone,
  output logic irq
);
  import tcbrc_pkg::*;

  // Refuse source counts the vector and stamp logic cannot serve
  if (NSRC < 2 || NSRC > 16) begin : g_nsrc_check
    $error("tcbrc_core: NSRC must lie in 2..16");
  end

  tcbrc_state_t state_reg;
  logic [7:0] xferCtrl_reg;
  logic [15:0] busExt_reg;
  logic [31:0] vecBase_reg;
  logic [IRQ_W-1:0] irqStat_reg;
  logic [IRQ_W-1:0] irqMask_reg;
  logic stopSeen_reg;
  logic [NSRC-1:0] pend_reg;
  logic [7:0] stamp_reg [NSRC];
  logic [7:0] seq_reg;
  logic [7:0] curVec_reg;
  logic [7:0] lastVec_reg;
  logic lastChain_reg;
  logic descValid_reg;
  logic [31:0] descPtr_reg;
  logic [31:0] desc_reg [4];
  logic [31:0] dataBuf_reg;
  logic [2:0] wordIdx_reg;
  logic nopYield_reg;

  // Register bus decode
  logic wrCtrl, wrBus, wrVec, wrStat, wrMask, rdCtrl;
  assign wrCtrl = regReq.we && regReq.addr == OFS_XFER_CTRL;
  assign wrBus = regReq.we && regReq.addr == OFS_BUS_EXT;
  assign wrVec = regReq.we && regReq.addr == OFS_VEC_BASE;
  assign wrStat = regReq.we && regReq.addr == OFS_IRQ_STAT;
  assign wrMask = regReq.we && regReq.addr == OFS_IRQ_MASK;
  assign rdCtrl = regReq.re && regReq.addr == OFS_XFER_CTRL;

  // Option bits
  logic skipEn, rchainEn, stopFlag;
  assign skipEn = xferCtrl_reg[XC_SKIP_BIT];
  assign rchainEn = xferCtrl_reg[XC_RCHAIN_BIT];
  assign stopFlag = xferCtrl_reg[XC_STOP_BIT];
  logic lockEn, nopRel, brstRel, burstHold, shortMode, cpuPri, arrivalOrd;
  assign lockEn = busExt_reg[BE_LOCK_BIT];
  assign nopRel = busExt_reg[BE_NOP_REL_BIT];
  assign brstRel = busExt_reg[BE_BRST_REL_BIT];
  assign burstHold = busExt_reg[BE_BURST_BIT];
  assign shortMode = busExt_reg[BE_SHORT_BIT];
  assign cpuPri = busExt_reg[BE_CPUPRI_BIT];
  assign arrivalOrd = !busExt_reg[BE_PRIO_BIT];

  // Descriptor size follows short mode
  logic [2:0] descWords;
  assign descWords = shortMode ? DESC_WORDS_SHORT : DESC_WORDS_LONG;

  // Lowest source index wins under fixed priority
  function automatic logic [7:0] pickFixed(input logic [NSRC-1:0] p);
    logic [7:0] r;
    r = 8'h00;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (p[i]) begin
        r = 8'(i);
      end
    end
    return r;
  endfunction

  // Oldest stamp wins; age relative to the sequence counter handles wrap
  function automatic logic [7:0] pickOldest(input logic [NSRC-1:0] p, input logic [7:0] now,
                                            input logic [7:0] st [NSRC]);
    logic [7:0] r;
    logic [7:0] bestAge;
    logic [7:0] age;
    logic found;
    r = 8'h00;
    bestAge = 8'h00;
    found = 1'b0;
    for (int i = 0; i < NSRC; i++) begin
      age = 8'(now - st[i]);
      // First pending source always taken, so a wrapped age of zero still wins
      if (p[i] && (!found || age > bestAge)) begin
        found = 1'b1;
        bestAge = age;
        r = 8'(i);
      end
    end
    return r;
  endfunction

  logic pendAny;
  logic [7:0] pickVec;
  assign pendAny = |pend_reg;
  assign pickVec = arrivalOrd ? pickOldest(pend_reg, seq_reg, stamp_reg) : pickFixed(pend_reg);

  // Skip decision made against the previous activation
  logic vecMatch, skipFetch;
  assign vecMatch = curVec_reg == lastVec_reg;
  assign skipFetch = vecMatch && skipEn && descValid_reg && !lastChain_reg;

  // Transfer counter location depends on descriptor size
  logic [15:0] cnt;
  logic [15:0] cntDec;
  assign cnt = shortMode ? desc_reg[0][15:0] : desc_reg[3][15:0];
  assign cntDec = 16'(cnt - 16'h0001);
  logic chainNext;
  assign chainNext = desc_reg[0][DM_CHAIN_BIT] &&
                     (!desc_reg[0][DM_REPEAT_BIT] || (cnt == 16'h0000 && rchainEn));

  // Stop event only counts while the engine is active
  logic active, stopEvent;
  assign active = state_reg != ST_IDLE && state_reg != ST_HALT;
  assign stopEvent = (addrErr || nmiReq) && active;

  // Bus yield conditions; CPU priority stalls accesses rather than aborting them
  logic yieldCpu, yieldDma, accState, lastDesc;
  assign yieldCpu = cpuPri && cpuExtReq;
  assign yieldDma = brstRel && burstDmaBusy && (state_reg == ST_DATA_RD || state_reg == ST_DATA_WR);
  assign accState = state_reg == ST_VEC || state_reg == ST_DESC_RD || state_reg == ST_DATA_RD ||
                    state_reg == ST_DATA_WR || state_reg == ST_DESC_WR;
  assign lastDesc = wordIdx_reg == 3'(descWords - 3'h1);

  // Bus request drops in idle, halt, the chain gap and any yield
  assign busReq = active && state_reg != ST_GAP && !nopYield_reg && !yieldCpu && !yieldDma;
  assign busOwn = busReq && busGnt;
  assign memReq = accState && busOwn;
  assign cpuHandlerOk = stopFlag && state_reg == ST_HALT;
  assign irq = |(irqStat_reg & irqMask_reg);
  assign burstDmaStart = timerCmpAIrq & busExt_reg[BE_TIMER_LSB +: BE_TIMER_W];

  // Memory address per state
  always_comb begin
    memCmd.write = state_reg == ST_DATA_WR || state_reg == ST_DESC_WR;
    memCmd.wdata = state_reg == ST_DATA_WR ? dataBuf_reg : desc_reg[wordIdx_reg[1:0]];
    case (state_reg)
      ST_VEC: memCmd.addr = vecBase_reg + {22'h000000, curVec_reg, 2'b00};
      ST_DESC_RD, ST_DESC_WR: memCmd.addr = descPtr_reg + {27'h0000000, wordIdx_reg, 2'b00};
      ST_DATA_RD: memCmd.addr = desc_reg[DW_SRC];
      ST_DATA_WR: memCmd.addr = desc_reg[DW_DST];
      default: memCmd.addr = 32'h0000_0000;
    endcase
  end

  logic ack;
  assign ack = memReq && memAck;

  // Sequencer
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (pendAny && !stopFlag) begin
            state_reg <= ST_ARB;
          end
        end
        ST_ARB: begin
          if (stopFlag) begin
            state_reg <= ST_HALT;
          end else if (busOwn) begin
            state_reg <= skipFetch ? ST_DATA_RD : ST_VEC;
          end
        end
        ST_VEC: begin
          if (ack) begin
            state_reg <= ST_NOP;
          end
        end
        ST_NOP: begin
          if (stopFlag) begin
            state_reg <= ST_HALT;
          end else if (busOwn) begin
            state_reg <= ST_DESC_RD;
          end
        end
        ST_DESC_RD: begin
          if (ack && lastDesc) begin
            state_reg <= stopFlag ? ST_HALT : ST_DATA_RD;
          end
        end
        ST_DATA_RD: begin
          if (ack) begin
            state_reg <= ST_DATA_WR;
          end
        end
        ST_DATA_WR: begin
          if (ack) begin
            state_reg <= (stopFlag || stopEvent) ? ST_HALT : ST_DESC_WR;
          end
        end
        ST_DESC_WR: begin
          if (ack && lastDesc) begin
            if (stopFlag || stopEvent) begin
              state_reg <= ST_HALT;
            end else if (chainNext) begin
              state_reg <= lockEn ? ST_DESC_RD : ST_GAP;
            end else if (burstHold && pendAny) begin
              state_reg <= ST_ARB;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_GAP: state_reg <= ST_DESC_RD;
        ST_HALT: begin
          if (!stopFlag) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Bus handed to CPU in the post-vector idle cycle while it asks
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nopYield_reg <= 1'b0;
    end else if (state_reg == ST_VEC && ack) begin
      nopYield_reg <= nopRel && cpuExtReq;
    end else if (state_reg != ST_NOP || !cpuExtReq) begin
      nopYield_reg <= 1'b0;
    end
  end

  // Word index for descriptor fetch and write-back
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wordIdx_reg <= 3'h0;
    end else if ((state_reg == ST_DESC_RD || state_reg == ST_DESC_WR) && ack) begin
      wordIdx_reg <= lastDesc ? 3'h0 : 3'(wordIdx_reg + 3'h1);
    end else if (state_reg == ST_IDLE || state_reg == ST_HALT) begin
      wordIdx_reg <= 3'h0;
    end
  end

  // Vector pointer, descriptor store and data buffer
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      descPtr_reg <= 32'h0000_0000;
      dataBuf_reg <= 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
        desc_reg[i] <= 32'h0000_0000;
      end
    end else begin
      if (state_reg == ST_VEC && ack) begin
        descPtr_reg <= memRdata;
      end
      if (state_reg == ST_DESC_WR && ack && lastDesc && chainNext) begin
        descPtr_reg <= descPtr_reg + {27'h0000000, descWords, 2'b00};
      end
      if (state_reg == ST_DESC_RD && ack) begin
        desc_reg[wordIdx_reg[1:0]] <= memRdata;
      end
      if (state_reg == ST_DATA_RD && ack) begin
        dataBuf_reg <= memRdata;
      end
      if (state_reg == ST_DATA_WR && ack) begin
        if (shortMode) begin
          desc_reg[0][15:0] <= cntDec;
        end else begin
          desc_reg[3][15:0] <= cntDec;
        end
      end
    end
  end

  // Activation history for the read skip
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      curVec_reg <= 8'h00;
      lastVec_reg <= 8'hff;
      lastChain_reg <= 1'b0;
      descValid_reg <= 1'b0;
    end else begin
      if ((state_reg == ST_IDLE || state_reg == ST_DESC_WR) && pendAny && !stopFlag) begin
        curVec_reg <= pickVec;
      end
      if (state_reg == ST_ARB && busOwn) begin
        lastVec_reg <= curVec_reg;
        lastChain_reg <= 1'b0;
      end
      if (state_reg == ST_DESC_RD && ack && lastDesc) begin
        descValid_reg <= 1'b1;
      end
      if (wrBus) begin
        descValid_reg <= 1'b0;
      end
      // Any chained link marks the whole activation, not only its last link
      if (state_reg == ST_DESC_WR && ack && lastDesc && chainNext) begin
        lastChain_reg <= 1'b1;
      end
    end
  end

  // Pending requests with arrival stamps; a new request beats the start-of-service clear
  logic takeReq;
  assign takeReq = state_reg == ST_ARB && busOwn;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_reg <= '0;
      seq_reg <= 8'h00;
      for (int i = 0; i < NSRC; i++) begin
        stamp_reg[i] <= 8'h00;
      end
    end else begin
      seq_reg <= 8'(seq_reg + 8'h01);
      for (int i = 0; i < NSRC; i++) begin
        if (actReq[i] && !pend_reg[i]) begin
          pend_reg[i] <= 1'b1;
          stamp_reg[i] <= seq_reg;
        end else if (takeReq && curVec_reg == 8'(i) && !actReq[i]) begin
          pend_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Transfer control: stop flag clears only after being read as one
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      xferCtrl_reg <= XC_RESET;
      stopSeen_reg <= 1'b0;
    end else begin
      if (wrCtrl) begin
        xferCtrl_reg[XC_SKIP_BIT] <= regReq.wdata[XC_SKIP_BIT];
        xferCtrl_reg[XC_RCHAIN_BIT] <= regReq.wdata[XC_RCHAIN_BIT];
      end
      if (stopEvent) begin
        xferCtrl_reg[XC_STOP_BIT] <= 1'b1;
      end else if (wrCtrl && !regReq.wdata[XC_STOP_BIT] && stopSeen_reg) begin
        xferCtrl_reg[XC_STOP_BIT] <= 1'b0;
      end
      if (rdCtrl && stopFlag) begin
        stopSeen_reg <= 1'b1;
      end else if (wrCtrl || !stopFlag) begin
        stopSeen_reg <= 1'b0;
      end
    end
  end

  // Bus extension and vector base; reserved bits never store
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busExt_reg <= BE_RESET;
      vecBase_reg <= VB_RESET;
    end else begin
      if (wrBus) begin
        busExt_reg <= regReq.wdata[15:0] & BE_WMASK;
      end
      if (wrVec) begin
        vecBase_reg <= regReq.wdata;
      end
    end
  end

  // Interrupt status, write one to clear; a new event wins over the clear
  logic [IRQ_W-1:0] irqSet;
  assign irqSet = {stopEvent, state_reg == ST_DESC_WR && ack && lastDesc && !chainNext};
  assign xferDone = irqSet[IRQ_DONE_BIT];
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqStat_reg <= '0;
      irqMask_reg <= '0;
    end else begin
      irqStat_reg <= (irqStat_reg & ~(wrStat ? regReq.wdata[IRQ_W-1:0] : '0)) | irqSet;
      if (wrMask) begin
        irqMask_reg <= regReq.wdata[IRQ_W-1:0];
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata <= 32'h0000_0000;
    end else if (regReq.re) begin
      case (regReq.addr)
        OFS_XFER_CTRL: regRdata <= {24'h000000, xferCtrl_reg};
        OFS_BUS_EXT: regRdata <= {16'h0000, busExt_reg};
        OFS_VEC_BASE: regRdata <= vecBase_reg;
        OFS_IRQ_STAT: regRdata <= {30'h0, irqStat_reg};
        OFS_IRQ_MASK: regRdata <= {30'h0, irqMask_reg};
        default: regRdata <= 32'h0000_0000;
      endcase
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end
endmodule

// ### tb/tcbrc_assertions.sv
`timescale 1ns/1ps
module tcbrc_assertions #(
  parameter int NSRC = 8
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire tcbrc_pkg::tcbrc_reg_req_t regReq,
  input wire logic [31:0] regRdata,
  input wire logic [4:0] timerCmpAIrq,
  input wire logic [4:0] burstDmaStart,
  input wire logic addrErr,
  input wire logic nmiReq,
  input wire logic cpuExtReq,
  input wire logic burstDmaBusy,
  input wire logic busReq,
  input wire logic busOwn,
  input wire logic memReq,
  input wire tcbrc_pkg::tcbrc_mem_req_t memCmd,
  input wire logic memAck,
  input wire logic cpuHandlerOk,
  input wire logic xferDone
);
  import tcbrc_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Bus side checks; the control bits themselves are only seen through reads
  a_burst_gate: assert property ((burstDmaStart & ~timerCmpAIrq) == 5'h00)
    else $error("burst start without timer irq");
  a_mem_owns_bus: assert property (memReq |-> busOwn)
    else $error("access without bus ownership");
  a_halt_bus_free: assert property (cpuHandlerOk |-> !busReq && !memReq)
    else $error("bus held while handler allowed");
  a_err_halts: assert property ((addrErr || nmiReq) && busOwn |-> ##[1:200] cpuHandlerOk)
    else $error("no halt after error event");
  a_halt_holds: assert property (cpuHandlerOk && !regReq.we |=> cpuHandlerOk)
    else $error("stop flag cleared without write");
  a_rdata_quiet: assert property (!$past(regReq.re) |-> regRdata == 32'h0)
    else $error("read data outside read cycle");
  a_done_on_ack: assert property (xferDone |-> memAck && memReq)
    else $error("done pulse away from last access");
  // Wait states without CPU or burst DMA requests must not disturb the pending access
  a_cmd_steady: assert property (memReq && !memAck && !cpuExtReq && !burstDmaBusy
    |=> memReq && $stable(memCmd))
    else $error("access changed before acknowledge");
  a_halt_no_done: assert property (cpuHandlerOk |-> !xferDone)
    else $error("transfer finished while halted");
endmodule

bind tcbrc_core tcbrc_assertions #(.NSRC(NSRC)) tcbrc_assertions_inst (.core_clk(core_clk), .sys_rst(sys_rst),
  .regReq(regReq), .regRdata(regRdata), .timerCmpAIrq(timerCmpAIrq), .burstDmaStart(burstDmaStart),
  .addrErr(addrErr), .nmiReq(nmiReq), .cpuExtReq(cpuExtReq), .burstDmaBusy(burstDmaBusy), .busReq(busReq),
  .busOwn(busOwn), .memReq(memReq), .memCmd(memCmd), .memAck(memAck), .cpuHandlerOk(cpuHandlerOk),
  .xferDone(xferDone));

// ### tb/tcbrc_mem_model.sv
`timescale 1ns/1ps
module tcbrc_mem_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic busReq,
  input wire logic memReq,
  input wire tcbrc_pkg::tcbrc_mem_req_t memCmd,
  output logic busGnt,
  output logic memAck,
  output logic [31:0] memRdata
);
  import tcbrc_pkg::*;
  logic [31:0] mem [256];
  logic [1:0] waitCnt;
  int acc;
  logic [31:0] firstRd;
  // Random latency 0..3; idle read data flips so stale values never match
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busGnt <= 1'b0;
      memAck <= 1'b0;
      waitCnt <= 2'h0;
      memRdata <= 32'h0;
    end else begin
      busGnt <= busReq;
      if (memAck) begin
        memAck <= 1'b0;
        memRdata <= ~memRdata;
      end else if (memReq && waitCnt == 2'h0) begin
        memAck <= 1'b1;
        memRdata <= mem[memCmd.addr[9:2]];
        if (memCmd.write)
          mem[memCmd.addr[9:2]] <= memCmd.wdata;
        if (acc == 0)
          firstRd <= memCmd.addr;
        acc <= acc + 1;
        waitCnt <= 2'($urandom_range(3));
      end else if (memReq) begin
        waitCnt <= waitCnt - 2'h1;
      end
    end
  end
endmodule

// ### tb/transfer_ctrl_bus_release_cfg_bench.sv
`timescale 1ns/1ps
module transfer_ctrl_bus_release_cfg_bench;
  import tcbrc_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  tcbrc_reg_req_t regReq;
  tcbrc_mem_req_t memCmd;
  logic [31:0] regRdata, memRdata, got, d;
  logic [7:0] actReq;
  logic [4:0] timerCmpAIrq, burstDmaStart;
  logic addrErr, nmiReq, cpuExtReq, burstDmaBusy, busReq, busGnt, busOwn, memReq, memAck;
  logic cpuHandlerOk, xferDone, irq;
  int failures = 0;
  int tests_run = 0;
  int v;
  always #50 core_clk = ~core_clk;
  tcbrc_core tcbrc_core_inst (.core_clk(core_clk), .sys_rst(sys_rst), .regReq(regReq), .regRdata(regRdata),
    .actReq(actReq), .addrErr(addrErr), .nmiReq(nmiReq), .cpuExtReq(cpuExtReq), .burstDmaBusy(burstDmaBusy),
    .timerCmpAIrq(timerCmpAIrq), .burstDmaStart(burstDmaStart), .busReq(busReq), .busGnt(busGnt),
    .busOwn(busOwn), .memReq(memReq), .memCmd(memCmd), .memAck(memAck), .memRdata(memRdata),
    .cpuHandlerOk(cpuHandlerOk), .xferDone(xferDone), .irq(irq));
  tcbrc_mem_model m (.core_clk(core_clk), .sys_rst(sys_rst), .busReq(busReq), .memReq(memReq),
    .memCmd(memCmd), .busGnt(busGnt), .memAck(memAck), .memRdata(memRdata));

  // Accesses per activation: vector plus descriptors unless skipped
  function automatic logic [31:0] accesses(input int n, input bit skip, input int links);
    return 32'((skip ? 0 : 1 + links * n) + links * (2 + n));
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    regReq <= '{we: 1'b1, re: 1'b0, addr: a, wdata: wd};
    @(posedge core_clk);
    regReq <= '0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    regReq <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 32'h0};
    @(posedge core_clk);
    regReq <= '0;
    #1 got = regRdata;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Descriptor chain at 0x100, sources at 0x200, destinations at 0x280
  task automatic prep(input int vec, input bit ch, input int n);
    m.mem[16 + vec] = 32'h100;
    for (int k = 0; k < 2; k++) begin
      m.mem[64 + k * n] = {ch && k == 0, 15'h0, 16'h1};
      m.mem[65 + k * n] = 32'(32'h200 + k * 4);
      m.mem[66 + k * n] = 32'(32'h280 + k * 4);
      if (n == 4)
        m.mem[67 + k * 4] = 32'h1;
      m.mem[128 + k] = $urandom;
      m.mem[160 + k] = 32'h0;
    end
  endtask
  task automatic run(input int vec, input logic [31:0] expAcc, input bit skip);
    int i;
    m.acc = 0;
    @(posedge core_clk);
    actReq <= 8'(1 << vec);
    @(posedge core_clk);
    actReq <= '0;
    for (i = 0; i < 400 && xferDone !== 1'b1; i++)
      tick(1);
    chk("accesses", expAcc, 32'(m.acc));
    if (!skip) begin
      chk("vector_addr", 32'(32'h40 + vec * 4), m.firstRd);
      chk("moved_data", m.mem[128], m.mem[160]);
    end
    $display("Test transfer vec %0d done", vec);
  endtask
  task automatic results();
    $display("Comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    regReq = '0;
    actReq = '0;
    addrErr = 1'b0;
    nmiReq = 1'b0;
    cpuExtReq = 1'b0;
    burstDmaBusy = 1'b0;
    timerCmpAIrq = '0;
    void'($urandom(32'h5d035de0));
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    // Reset values, including an unmapped place
    for (int i = 0; i < 6; i++) begin
      rd(8'(i * 4));
      chk("reset_value", 32'h0, got);
    end
    wr(OFS_XFER_CTRL, 32'hff);
    rd(OFS_XFER_CTRL);
    chk("ctrl_reserved", 32'h18, got);
    repeat (4) begin
      d = $urandom;
      wr(OFS_BUS_EXT, d);
      rd(OFS_BUS_EXT);
      chk("bus_ext", d & {16'h0, BE_WMASK}, got);
      repeat (4) begin
        @(posedge core_clk);
        timerCmpAIrq <= 5'($urandom);
        tick(1);
        chk("burst_start", {27'h0, timerCmpAIrq & d[4:0]}, {27'h0, burstDmaStart});
      end
    end
    $display("Test registers done");
    wr(OFS_BUS_EXT, 32'h0);
    wr(OFS_VEC_BASE, 32'h40);
    wr(OFS_XFER_CTRL, 32'h10);
    v = $urandom_range(7);
    prep(v, 1'b0, 4);
    run(v, accesses(4, 1'b0, 1), 1'b0);
    run(v, accesses(4, 1'b1, 1), 1'b1);
    v = (v + 1) % 8;
    prep(v, 1'b0, 4);
    run(v, accesses(4, 1'b0, 1), 1'b0);
    wr(OFS_BUS_EXT, 32'h400);
    prep(v, 1'b0, 3);
    run(v, accesses(3, 1'b0, 1), 1'b0);
    wr(OFS_BUS_EXT, 32'h8000);
    for (int r = 0; r < 2; r++) begin
      prep(v, 1'b1, 4);
      run(v, accesses(4, 1'b0, 2), 1'b0);
    end
    // CPU external priority stalls the engine until the CPU lets go
    wr(OFS_BUS_EXT, 32'h200);
    prep(v, 1'b0, 4);
    cpuExtReq <= 1'b1;
    fork
      run(v, accesses(4, 1'b0, 1), 1'b0);
      begin
        tick(30);
        chk("cpu_priority", 32'h0, 32'(m.acc));
        @(posedge core_clk);
        cpuExtReq <= 1'b0;
      end
    join
    $display("Test cpu priority done");
    // Requests raised during a transfer: burst hold keeps the bus, lowest index next
    wr(OFS_BUS_EXT, 32'h900);
    prep(1, 1'b0, 4);
    prep(7, 1'b0, 4);
    @(posedge core_clk);
    actReq <= 8'h80;
    @(posedge core_clk);
    actReq <= 8'h20;
    @(posedge core_clk);
    actReq <= 8'h02;
    @(posedge core_clk);
    actReq <= '0;
    for (int i = 0; i < 400 && xferDone !== 1'b1; i++)
      tick(1);
    m.acc = 0;
    tick(1);
    chk("burst_hold", 32'h1, {31'h0, busReq});
    for (int i = 0; i < 400 && xferDone !== 1'b1; i++)
      tick(1);
    chk("fixed_priority", 32'h44, m.firstRd);
    tick(1);
    for (int i = 0; i < 400 && xferDone !== 1'b1; i++)
      tick(1);
    tick(4);
    $display("Test burst priority done");
    // Address error with the stop interrupt unmasked, then NMI with it masked
    for (int e = 0; e < 2; e++) begin
      wr(OFS_IRQ_STAT, 32'h3);
      wr(OFS_IRQ_MASK, e == 0 ? 32'h2 : 32'h0);
      prep(v, 1'b0, 4);
      @(posedge core_clk);
      actReq <= 8'(1 << v);
      @(posedge core_clk);
      actReq <= '0;
      for (int i = 0; i < 50 && busOwn !== 1'b1; i++)
        tick(1);
      @(posedge core_clk);
      addrErr <= e == 0;
      nmiReq <= e == 1;
      @(posedge core_clk);
      addrErr <= 1'b0;
      nmiReq <= 1'b0;
      for (int i = 0; i < 300 && cpuHandlerOk !== 1'b1; i++)
        tick(1);
      chk("halted", 32'h1, {31'h0, cpuHandlerOk});
      chk("irq_level", {31'h0, e == 0}, {31'h0, irq});
      m.acc = 0;
      @(posedge core_clk);
      actReq <= 8'(1 << v);
      @(posedge core_clk);
      actReq <= '0;
      tick(20);
      chk("no_start", 32'h0, 32'(m.acc));
      wr(OFS_XFER_CTRL, 32'h10);
      rd(OFS_XFER_CTRL);
      chk("stop_kept", 32'h11, got);
      wr(OFS_XFER_CTRL, 32'h10);
      rd(OFS_XFER_CTRL);
      chk("stop_cleared", 32'h10, got);
      rd(OFS_IRQ_STAT);
      chk("stop_status", 32'h2, got & 32'h2);
      wr(OFS_IRQ_STAT, 32'h3);
      tick(150);
      wr(OFS_IRQ_STAT, 32'h3);
      tick(1);
      chk("irq_clear", 32'h0, {31'h0, irq});
      $display("Test stop event %0d done", e);
    end
    results();
  end
  // Whole run takes far below this span
  initial begin
    #(100 * 20000);
    failures++;
    $display("Watchdog expired");
    results();
  end
endmodule
